// ==== rtl/cpu_instruction_decode.sv ====
// Instruction decode and execute for converter, power-down, watchdog,
// lookup-bank and voltage-drop instructions of a 4-bit CPU core.
// Assumes program memory presents one word per INSTR_VALID cycle, and
// that the datapath outside runs the remaining instruction classes.
//
// The implementer's own choices: register access over APB and the register offsets.
module cpu_instruction_decode
    import decode_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              INSTR_VALID,
    input  wire logic [WORD_W-1:0] INSTR_WORD,
    output logic                   INSTR_READY,
    input  wire logic [9:0]        CONV_RESULT,
    input  wire logic              CONV_DONE_SET,
    input  wire logic              WDT_TIMEOUT_SET,
    input  wire logic              POWER_FLAG,
    input  wire logic              VOLTAGE_DROP_PIN_GATE,
    input  wire logic              WAKE,
    output exec_t                  EXEC,
    output logic                   CONV_START,
    output logic                   CONV_COMPARE,
    output logic [7:0]             COMPARE_VALUE,
    output logic [11:0]            CONV_CTRL,
    output logic                   LOOKUP_STROBE,
    output logic [6:0]             LOOKUP_PAGE,
    output logic                   WDT_RUN,
    output pd_mode_t               PD_MODE,
    output logic                   VDROP_DETECT_EN
);

    typedef enum logic {ST_FIRST, ST_SECOND} fetch_t;

    fetch_t            fetch_reg;
    logic              drop_reg;
    logic              skip_reg;
    logic [WORD_W-1:0] first_reg;
    logic [3:0]        acc_reg;
    logic [3:0]        b_reg;
    logic [3:0]        q1_reg;
    logic [3:0]        q2_reg;
    logic [3:0]        q3_reg;
    logic [3:0]        irq_reg;
    logic [7:0]        cmp_reg;
    logic              cdone_reg;
    logic              wdf_reg;
    logic              wdrun_reg;
    logic              wdarm_reg;
    logic              pdarm_reg;
    logic              bank_reg;
    logic              vdarm_reg;
    logic              fmterr_reg;
    pd_mode_t          pd_reg;

    function automatic logic is_two_word(input logic [WORD_W-1:0] w);
        logic [5:0] col;
        col = w[9:4];
        is_two_word = (w == OP_IJMP) || (w == OP_ICALL)
            || (w == OP_PBIT) || (w == OP_CMPI)
            || (col[5:1] == COL_LCALL) || (col[5:1] == COL_LJMP);
    endfunction

    // Second-word legality per first-word class
    function automatic logic second_ok(input logic [WORD_W-1:0] f,
                                       input logic [WORD_W-1:0] s);
        logic ok;
        ok = 1'b1;
        if (f == OP_IJMP || f == OP_ICALL)
            ok = s[9] && (s[5:4] == 2'b00);
        else if (f == OP_CMPI)
            ok = (s[9:4] == SEC_CMPI_HI);
        else if (f == OP_PBIT)
            ok = (s == SEC_PBIT);
        else
            ok = s[9];
        second_ok = ok;
    endfunction

    logic              first_slot;
    logic              two_word_in;
    logic              exec_one;
    logic              exec_two;
    logic              go;
    logic [WORD_W-1:0] op;
    logic [WORD_W-1:0] sec;
    logic              word_taken;

    assign INSTR_READY = 1'b1;
    assign word_taken  = INSTR_VALID;
    assign first_slot  = INSTR_VALID && (fetch_reg == ST_FIRST);
    assign two_word_in = is_two_word(INSTR_WORD);
    assign exec_one    = first_slot && !skip_reg && !two_word_in;
    assign exec_two    = INSTR_VALID && (fetch_reg == ST_SECOND)
                         && !drop_reg;
    assign go          = exec_one || exec_two;
    assign op          = exec_two ? first_reg : INSTR_WORD;
    assign sec         = exec_two ? INSTR_WORD : 10'h000;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fetch_reg <= ST_FIRST;
            drop_reg  <= 1'b0;
            first_reg <= 10'h000;
        end
        else if (first_slot && two_word_in)
        begin
            fetch_reg <= ST_SECOND;
            drop_reg  <= skip_reg;
            first_reg <= INSTR_WORD;
        end
        else if (INSTR_VALID)
        begin
            fetch_reg <= ST_FIRST;
            drop_reg  <= 1'b0;
        end
    end

    // Skip decision for the executing instruction
    logic skip_now;
    always_comb
    begin
        skip_now = 1'b0;
        if (go)
        begin
            if (op == OP_CDONE)
                skip_now = !irq_reg[CONV_IRQ_BIT] && cdone_reg;
            else if (op == OP_PFLAG)
                skip_now = POWER_FLAG;
            else if (op == OP_WDRST)
                skip_now = wdf_reg;
            else if (op == OP_CMPI)
                skip_now = (acc_reg == sec[3:0]);
        end
    end

    // Skipped instruction is consumed whole, both words if two
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            skip_reg <= 1'b0;
        else if (go)
            skip_reg <= skip_now;
        else if (first_slot)
            skip_reg <= 1'b0;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            EXEC <= '0;
        else
        begin
            EXEC.valid  <= go;
            EXEC.skip   <= skip_now;
            EXEC.first  <= go ? op : EXEC.first;
            EXEC.second <= go ? sec : EXEC.second;
        end
    end

    // APB access phase, zero wait states
    logic apb_wr;
    logic addr_ok;
    assign apb_wr  = PSEL && PENABLE && PWRITE;
    assign addr_ok = (PADDR == ADDR_ACC) || (PADDR == ADDR_CONV)
                     || (PADDR == ADDR_IRQ) || (PADDR == ADDR_STATUS)
                     || (PADDR == ADDR_CMP);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            fmterr_reg <= 1'b0;
        else if (exec_two && !second_ok(first_reg, INSTR_WORD))
            fmterr_reg <= 1'b1;
        else if (apb_wr && PADDR == ADDR_STATUS && PWDATA[ST_FMTERR])
            fmterr_reg <= 1'b0;
    end

    // Accumulator and B, converter transfers
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            acc_reg <= NIB_RST;
            b_reg   <= NIB_RST;
        end
        else if (go && op == OP_RHIMID)
        begin
            if (q1_reg[CMP_MODE_BIT])
            begin
                b_reg   <= CONV_RESULT[7:4];
                acc_reg <= CONV_RESULT[3:0];
            end
            else
            begin
                b_reg   <= CONV_RESULT[9:6];
                acc_reg <= CONV_RESULT[5:2];
            end
        end
        else if (go && op == OP_RLOW2)
            acc_reg <= {CONV_RESULT[1:0], 2'b00};
        else if (go && op == OP_RQ1)
            acc_reg <= q1_reg;
        else if (go && op == OP_RQ2)
            acc_reg <= q2_reg;
        else if (go && op == OP_RQ3)
            acc_reg <= q3_reg;
        else if (apb_wr && PADDR == ADDR_ACC)
        begin
            acc_reg <= PWDATA[3:0];
            b_reg   <= PWDATA[7:4];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            q1_reg <= NIB_RST;
            q2_reg <= NIB_RST;
            q3_reg <= NIB_RST;
        end
        else if (go && op == OP_WQ1)
            q1_reg <= acc_reg;
        else if (go && op == OP_WQ2)
            q2_reg <= acc_reg;
        else if (go && op == OP_WQ3)
            q3_reg <= acc_reg;
        else if (apb_wr && PADDR == ADDR_CONV)
        begin
            q1_reg <= PWDATA[3:0];
            q2_reg <= PWDATA[7:4];
            q3_reg <= PWDATA[11:8];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            irq_reg <= NIB_RST;
        else if (apb_wr && PADDR == ADDR_IRQ)
            irq_reg <= PWDATA[3:0];
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            cmp_reg <= 8'h00;
        else if (go && op == OP_WCMP && q1_reg[CMP_MODE_BIT])
            cmp_reg <= {b_reg, acc_reg};
    end

    // Set wins so a completion landing on the clear is kept
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            cdone_reg <= 1'b0;
        else if (CONV_DONE_SET)
            cdone_reg <= 1'b1;
        else if (go && op == OP_CSTART)
            cdone_reg <= 1'b0;
        else if (go && op == OP_CDONE && skip_now)
            cdone_reg <= 1'b0;
        else if (apb_wr && PADDR == ADDR_STATUS && PWDATA[ST_CDONE])
            cdone_reg <= 1'b0;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CONV_START   <= 1'b0;
            CONV_COMPARE <= 1'b0;
        end
        else
        begin
            CONV_START   <= go && (op == OP_CSTART);
            CONV_COMPARE <= q1_reg[CMP_MODE_BIT];
        end
    end

    // flag clear after skip, timeout set wins
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            wdf_reg <= 1'b0;
        else if (WDT_TIMEOUT_SET)
            wdf_reg <= 1'b1;
        else if (go && op == OP_WDRST && skip_now)
            wdf_reg <= 1'b0;
        else if (apb_wr && PADDR == ADDR_STATUS && PWDATA[ST_WDF])
            wdf_reg <= 1'b0;
    end

    // stop needs restart right after stop-arm
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wdarm_reg <= 1'b0;
            wdrun_reg <= 1'b1;
        end
        else if (word_taken && fetch_reg == ST_FIRST)
        begin
            wdarm_reg <= exec_one && (op == OP_WDARM);
            if (exec_one && op == OP_WDRST && wdarm_reg)
                wdrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            pdarm_reg <= 1'b0;
        else if (word_taken && fetch_reg == ST_FIRST)
            pdarm_reg <= exec_one && (op == OP_PDARM);
    end

    // Power-down entry; WAKE returns to run
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            pd_reg <= PD_RUN;
        else if (WAKE)
            pd_reg <= PD_RUN;
        else if (exec_one && op == OP_CLKPD && pdarm_reg)
            pd_reg <= PD_CLOCK;
        else if (exec_one && op == OP_RAMPD && pdarm_reg)
            pd_reg <= PD_RAM;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            bank_reg <= 1'b0;
        else if (go && op == OP_BANKLO)
            bank_reg <= 1'b0;
        else if (go && op == OP_BANKHI)
            bank_reg <= 1'b1;
    end

    // Page columns 08..0B carry the 6-bit page
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            LOOKUP_STROBE <= 1'b0;
            LOOKUP_PAGE   <= 7'h00;
        end
        else
        begin
            LOOKUP_STROBE <= go && (op[9:6] == COL_LOOKUP);
            if (go && op[9:6] == COL_LOOKUP)
                LOOKUP_PAGE <= {bank_reg, op[5:0]};
        end
    end

    // Arm latches; detector only live in power-down with pin high
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            vdarm_reg <= 1'b0;
        else if (go && op == OP_VDARM)
            vdarm_reg <= 1'b1;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            VDROP_DETECT_EN <= 1'b0;
        else
            VDROP_DETECT_EN <= vdarm_reg && (pd_reg != PD_RUN)
                               && VOLTAGE_DROP_PIN_GATE;
    end

    assign COMPARE_VALUE = cmp_reg;
    assign CONV_CTRL     = {q3_reg, q2_reg, q1_reg};
    assign WDT_RUN       = wdrun_reg;
    assign PD_MODE       = pd_reg;

    logic [31:0] status;
    always_comb
    begin
        status             = 32'h0000_0000;
        status[ST_CDONE]   = cdone_reg;
        status[ST_WDF]     = wdf_reg;
        status[ST_WDRUN]   = wdrun_reg;
        status[ST_BANK]    = bank_reg;
        status[ST_VDARM]   = vdarm_reg;
        status[ST_FMTERR]  = fmterr_reg;
        status[ST_PDARM]   = pdarm_reg;
        status[ST_PDCLK]   = (pd_reg == PD_CLOCK);
        status[ST_PDRAM]   = (pd_reg == PD_RAM);
    end

    // Read data registered at the setup-phase edge
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            unique case (PADDR)
                ADDR_ACC:    PRDATA <= {24'h00_0000, b_reg, acc_reg};
                ADDR_CONV:   PRDATA <= {20'h0_0000, CONV_CTRL};
                ADDR_IRQ:    PRDATA <= {28'h000_0000, irq_reg};
                ADDR_STATUS: PRDATA <= status;
                ADDR_CMP:    PRDATA <= {24'h00_0000, cmp_reg};
                default:     PRDATA <= 32'h0000_0000;
            endcase
        end
    end


endmodule

// ==== rtl/decode_pkg.sv ====
// Package: opcode map, APB register map and carrier types for the
// instruction decode block.
// Assumes a 10-bit instruction word and a 32-bit APB register bus.
package decode_pkg;

    localparam int WORD_W = 10;
    localparam int NIB_W  = 4;

    // Single-word opcodes: bits 9..4 column, bits 3..0 row
    localparam logic [9:0] OP_NOP    = 10'h000;
    localparam logic [9:0] OP_CLKPD  = 10'h002;
    localparam logic [9:0] OP_PFLAG  = 10'h003;
    localparam logic [9:0] OP_RAMPD  = 10'h008;
    localparam logic [9:0] OP_BANKLO = 10'h040;
    localparam logic [9:0] OP_BANKHI = 10'h041;
    localparam logic [9:0] OP_PDARM  = 10'h05B;
    localparam logic [9:0] OP_WQ1    = 10'h204;
    localparam logic [9:0] OP_WQ2    = 10'h205;
    localparam logic [9:0] OP_WQ3    = 10'h206;
    localparam logic [9:0] OP_WCMP   = 10'h239;
    localparam logic [9:0] OP_RQ1    = 10'h244;
    localparam logic [9:0] OP_RQ2    = 10'h245;
    localparam logic [9:0] OP_RQ3    = 10'h246;
    localparam logic [9:0] OP_RLOW2  = 10'h249;
    localparam logic [9:0] OP_RHIMID = 10'h279;
    localparam logic [9:0] OP_CDONE  = 10'h287;
    localparam logic [9:0] OP_VDARM  = 10'h293;
    localparam logic [9:0] OP_WDARM  = 10'h29C;
    localparam logic [9:0] OP_CSTART = 10'h29F;
    localparam logic [9:0] OP_WDRST  = 10'h2A0;

    // Two-word first words
    localparam logic [9:0] OP_IJMP   = 10'h010;
    localparam logic [9:0] OP_PBIT   = 10'h024;
    localparam logic [9:0] OP_CMPI   = 10'h025;
    localparam logic [9:0] OP_ICALL  = 10'h030;
    localparam logic [4:0] COL_LCALL = 5'h06;
    localparam logic [4:0] COL_LJMP  = 5'h07;

    // Lookup page columns 08..0B, page in low 6 bits
    localparam logic [3:0] COL_LOOKUP = 4'h2;

    // Second-word fixed fields
    localparam logic [5:0] SEC_CMPI_HI = 6'h07;
    localparam logic [9:0] SEC_PBIT    = 10'h02B;

    // Converter control 1 bit 3 selects comparator mode
    localparam int CMP_MODE_BIT = 3;
    // Interrupt control bit 2 turns skip_on_conversion_done into a no-op
    localparam int CONV_IRQ_BIT = 2;

    // APB register map, byte addresses
    localparam logic [7:0] ADDR_ACC    = 8'h00;
    localparam logic [7:0] ADDR_CONV   = 8'h04;
    localparam logic [7:0] ADDR_IRQ    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CMP    = 8'h10;

    // Status bit positions
    localparam int ST_CDONE  = 0;
    localparam int ST_WDF    = 1;
    localparam int ST_WDRUN  = 2;
    localparam int ST_BANK   = 3;
    localparam int ST_VDARM  = 4;
    localparam int ST_FMTERR = 5;
    localparam int ST_PDARM  = 6;
    localparam int ST_PDCLK  = 7;
    localparam int ST_PDRAM  = 8;

    localparam logic [3:0] NIB_RST = 4'h0;

    typedef enum logic [1:0] {PD_RUN, PD_CLOCK, PD_RAM} pd_mode_t;

    typedef struct packed {
        logic              valid;
        logic              skip;
        logic [WORD_W-1:0] first;
        logic [WORD_W-1:0] second;
    } exec_t;

endpackage

// ==== tb/decode_chk.sv ====
// Checker: decoded effects at the decode block's ports.
// Assumes effects land in the cycle that EXEC.valid is high.
module decode_chk
    import decode_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        INSTR_VALID,
    input wire logic [9:0]  INSTR_WORD,
    input wire exec_t       EXEC,
    input wire logic        CONV_START,
    input wire logic [11:0] CONV_CTRL,
    input wire logic        LOOKUP_STROBE,
    input wire logic [6:0]  LOOKUP_PAGE,
    input wire logic        WDT_RUN,
    input wire pd_mode_t    PD_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] last_reg;
    logic       bank_reg;
    logic       ex;
    logic [9:0] op;
    assign ex = EXEC.valid;
    assign op = EXEC.first;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    // Arming only counts for the very next executed word
    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST)
            last_reg <= OP_NOP;
        else if (ex)
            last_reg <= op;

    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST)
            bank_reg <= 1'b0;
        else if (ex && op == OP_BANKHI)
            bank_reg <= 1'b1;
        else if (ex && op == OP_BANKLO)
            bank_reg <= 1'b0;

    property p_start;
        CONV_START == (ex && op == OP_CSTART);
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse without start opcode");
    property p_page;
        ex && op[9:6] == COL_LOOKUP |->
            LOOKUP_STROBE && LOOKUP_PAGE == {bank_reg, op[5:0]};
    endproperty
    a_page: assert property (p_page)
        else $error("lookup page wrong");
    property p_clkpd;
        ex && op == OP_CLKPD && last_reg == OP_PDARM |-> PD_MODE == PD_CLOCK;
    endproperty
    a_clkpd: assert property (p_clkpd)
        else $error("armed power-down not taken");
    property p_unarmed;
        ex && (op == OP_CLKPD || op == OP_RAMPD) && last_reg != OP_PDARM
            && $past(PD_MODE) == PD_RUN |-> PD_MODE == PD_RUN;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("unarmed power-down took effect");
    property p_wdstop;
        $fell(WDT_RUN) |-> ex && op == OP_WDRST && last_reg == OP_WDARM;
    endproperty
    a_wdstop: assert property (p_wdstop)
        else $error("watchdog stopped out of order");
    property p_nop;
        ex && op == OP_NOP |-> !CONV_START && !LOOKUP_STROBE
            && $stable(CONV_CTRL) && $stable(WDT_RUN);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-op changed state");
    property p_second;
        ex && op == OP_CMPI |-> EXEC.second == $past(INSTR_WORD)
            && $past(INSTR_WORD, 2) == OP_CMPI;
    endproperty
    a_second: assert property (p_second)
        else $error("second word not paired");
    property p_one;
        ex && EXEC.second == 10'h000 |->
            $past(INSTR_VALID) && op == $past(INSTR_WORD);
    endproperty
    a_one: assert property (p_one)
        else $error("executed word not the word taken");

    c_pdclk: cover property (PD_MODE == PD_CLOCK);
    c_wdstop: cover property ($fell(WDT_RUN));
    c_upper: cover property (LOOKUP_STROBE && LOOKUP_PAGE[6]);
endmodule

bind cpu_instruction_decode decode_chk u_decode_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .EXEC(EXEC), .CONV_START(CONV_START),
    .CONV_CTRL(CONV_CTRL), .LOOKUP_STROBE(LOOKUP_STROBE),
    .LOOKUP_PAGE(LOOKUP_PAGE), .WDT_RUN(WDT_RUN), .PD_MODE(PD_MODE)
);

// ==== tb/prog_mem.sv ====
// Program memory model: hands queued words to the decoder.
// Assumes the decoder takes a word on every valid cycle.
module prog_mem
    import decode_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    output logic                   instr_valid,
    output logic [WORD_W-1:0]      instr_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] q[$];

    // bench queues assigned codes, pages, second words and one unassigned code
    task automatic push(input logic [WORD_W-1:0] w);
        q.push_back(w);
    endtask

    // Idle word toggles so stale data never looks valid
    always @(posedge clk or posedge rst)
        if (rst)
        begin
            instr_valid <= 1'b0;
            instr_word  <= 10'h3FF;
        end
        else if (q.size() != 0)
        begin
            instr_valid <= 1'b1;
            instr_word  <= q.pop_front();
        end
        else
        begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
endmodule

// ==== tb/tb_top.sv ====
// Top bench: program memory model, APB master tasks, decoder.
// Assumes the bound checker and a 125 MHz clock.
module tb_top
    import decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0]  PADDR, COMPARE_VALUE;
    logic [31:0] PWDATA, PRDATA, r;
    logic [9:0]  INSTR_WORD, CONV_RESULT;
    logic        INSTR_VALID, CONV_DONE_SET, WDT_TIMEOUT_SET, WAKE;
    logic        POWER_FLAG, VOLTAGE_DROP_PIN_GATE, CONV_START;
    logic        CONV_COMPARE, LOOKUP_STROBE, WDT_RUN, VDROP_DETECT_EN;
    logic [6:0]  LOOKUP_PAGE;
    logic [11:0] CONV_CTRL;
    exec_t       EXEC;
    pd_mode_t    PD_MODE;
    int          err_total = 0;
    int          cmp_count = 0;
    int          n_exec = 0;
    int          n_start = 0;
    int          s;
    logic [9:0]  tw [12] = '{OP_IJMP, 10'h20F, OP_IJMP, 10'h230,
        10'h0E0, 10'h2FF, 10'h0E0, 10'h0F0, OP_CMPI, 10'h073,
        OP_CMPI, 10'h1F3};

    cpu_instruction_decode u_cpu_instruction_decode (
        .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID),
        .INSTR_WORD(INSTR_WORD), .INSTR_READY(), .CONV_RESULT(CONV_RESULT),
        .CONV_DONE_SET(CONV_DONE_SET), .WDT_TIMEOUT_SET(WDT_TIMEOUT_SET),
        .POWER_FLAG(POWER_FLAG), .WAKE(WAKE), .EXEC(EXEC),
        .VOLTAGE_DROP_PIN_GATE(VOLTAGE_DROP_PIN_GATE),
        .CONV_START(CONV_START), .CONV_COMPARE(CONV_COMPARE),
        .COMPARE_VALUE(COMPARE_VALUE), .CONV_CTRL(CONV_CTRL),
        .LOOKUP_STROBE(LOOKUP_STROBE), .LOOKUP_PAGE(LOOKUP_PAGE),
        .WDT_RUN(WDT_RUN), .PD_MODE(PD_MODE),
        .VDROP_DETECT_EN(VDROP_DETECT_EN));
    prog_mem u_prog_mem (.clk(CLK), .rst(SYS_RST),
        .instr_valid(INSTR_VALID), .instr_word(INSTR_WORD));

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        n_exec  <= n_exec + int'(EXEC.valid);
        n_start <= n_start + int'(CONV_START);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CLK);
        while (PREADY !== 1'b1);
        r = PRDATA;
        chk(PSLVERR, 32'(a > ADDR_CMP));
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, e);
    endtask

    task automatic settle;
        repeat (u_prog_mem.q.size() + 3) @(posedge CLK);
    endtask

    task automatic op(input logic [9:0] w);
        u_prog_mem.push(w);
        settle;
    endtask

    // One-cycle pulse: 0 done flag, 1 watchdog flag, 2 wake
    task automatic pulse(input int k);
        {WAKE, WDT_TIMEOUT_SET, CONV_DONE_SET} <= 3'b001 << k;
        @(posedge CLK);
        {WAKE, WDT_TIMEOUT_SET, CONV_DONE_SET} <= 3'b000;
        @(posedge CLK);
    endtask

    task automatic results;
        $display("errors %0d checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_total++;
        results;
    end

    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {CONV_DONE_SET, WDT_TIMEOUT_SET, WAKE, POWER_FLAG} = '0;
        VOLTAGE_DROP_PIN_GATE = 1'b1;
        CONV_RESULT = 10'h2D6;
        SYS_RST = 1'b1;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(ADDR_STATUS, 32'h0000_0004);
        op(OP_RHIMID);
        rd(ADDR_ACC, 32'h0000_00B5);
        wr(ADDR_CONV, 32'h0000_0008);
        op(OP_RHIMID);
        rd(ADDR_ACC, 32'h0000_00D6);
        op(OP_RLOW2);
        rd(ADDR_ACC, 32'h0000_00D8);
        wr(ADDR_ACC, 32'h0000_003C);
        op(OP_WCMP);
        rd(ADDR_CMP, 32'h0000_003C);
        op(OP_CSTART);
        chk(CONV_COMPARE, 32'h1);
        wr(ADDR_CONV, 32'h0000_0000);
        wr(ADDR_ACC, 32'h0000_005A);
        op(OP_WCMP);
        chk(COMPARE_VALUE, 32'h3C);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_CONV, 32'h0000_0000);
            wr(ADDR_ACC, 32'(i + 5));
            op(OP_WQ1 + 10'(i));
            rd(ADDR_CONV, 32'(i + 5) << (4 * i));
            wr(ADDR_ACC, 32'h0000_0000);
            op(OP_RQ1 + 10'(i));
            rd(ADDR_ACC, 32'(i + 5));
        end
        pulse(0);
        rd(ADDR_STATUS, 32'h0000_0005);
        op(OP_CSTART);
        rd(ADDR_STATUS, 32'h0000_0004);
        pulse(0);
        s = n_exec;
        u_prog_mem.push(OP_CDONE);
        op(OP_CSTART);
        chk(n_exec - s, 1);
        chk(n_start, 2);
        wr(ADDR_IRQ, 32'h0000_0004);
        pulse(0);
        op(OP_CDONE);
        rd(ADDR_STATUS, 32'h0000_0005);
        wr(ADDR_IRQ, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_0001);
        POWER_FLAG <= 1'b1;
        s = n_exec;
        u_prog_mem.push(OP_PFLAG);
        op(OP_NOP);
        chk(n_exec - s, 1);
        POWER_FLAG <= 1'b0;
        pulse(1);
        s = n_exec;
        u_prog_mem.push(OP_WDRST);
        op(OP_NOP);
        chk(n_exec - s, 1);
        rd(ADDR_STATUS, 32'h0000_0004);
        u_prog_mem.push(OP_WDARM);
        u_prog_mem.push(OP_NOP);
        op(OP_WDRST);
        chk(WDT_RUN, 32'h1);
        u_prog_mem.push(OP_WDARM);
        op(OP_WDRST);
        chk(WDT_RUN, 32'h0);
        op(OP_VDARM);
        op(OP_CLKPD);
        chk(PD_MODE, PD_RUN);
        u_prog_mem.push(OP_PDARM);
        u_prog_mem.push(OP_NOP);
        op(OP_CLKPD);
        chk(PD_MODE, PD_RUN);
        u_prog_mem.push(OP_PDARM);
        op(OP_CLKPD);
        chk(PD_MODE, PD_CLOCK);
        chk(VDROP_DETECT_EN, 32'h1);
        pulse(2);
        u_prog_mem.push(OP_PDARM);
        op(OP_RAMPD);
        chk(PD_MODE, PD_RAM);
        VOLTAGE_DROP_PIN_GATE <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(VDROP_DETECT_EN, 32'h0);
        pulse(2);
        op(10'h085);
        chk(LOOKUP_PAGE, 32'h05);
        op(OP_BANKHI);
        op(10'h0BF);
        chk(LOOKUP_PAGE, 32'h7F);
        op(OP_BANKLO);
        op(10'h080);
        chk(LOOKUP_PAGE, 32'h00);
        wr(ADDR_ACC, 32'h0000_0007);
        s = n_start;
        u_prog_mem.push(OP_CMPI);
        u_prog_mem.push(10'h077);
        op(OP_CSTART);
        chk(n_start - s, 0);
        u_prog_mem.push(OP_CMPI);
        u_prog_mem.push(10'h076);
        op(OP_CSTART);
        chk(n_start - s, 1);
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_STATUS, 32'h0000_0020);
            u_prog_mem.push(tw[2 * i]);
            op(tw[2 * i + 1]);
            chk(EXEC.second, tw[2 * i + 1]);
            rd(ADDR_STATUS, 32'h10 | (32'(i % 2) << 5));
        end
        rd(8'h20, 32'h0000_0000);
        wr(ADDR_CMP, 32'h0000_FFFF);
        rd(ADDR_CMP, 32'h0000_003C);
        op(10'h35A);
        chk(EXEC.first, 10'h35A);
        results;
    end
endmodule
